// ==== include/asspc_defs.svh ====
/*
 * Constants for the address strap and status pin control block.
 * Assumes nothing beyond a single 20 MHz clock domain.
 */
`ifndef ASSPC_DEFS_SVH
`define ASSPC_DEFS_SVH

// Configuration bus target address for a low strap level.
`define ASSPC_ADDR_LOW      8'hB0
// Address step added for a high strap level, giving 0xB2.
`define ASSPC_ADDR_STEP     8'h02
// Cycles after power-on release before the strap is taken, so the synchroniser is full.
`define ASSPC_SETTLE_CYCLES 3'h4
// Reset value of the settle counter.
`define ASSPC_SETTLE_RESET  3'h0
// Synchroniser depth for pin inputs.
`define ASSPC_SYNC_DEPTH    3

`endif

// ==== include/asspc_pkg.sv ====
/*
 * Types for the address strap and status pin control block.
 * Assumes the constants header is compiled alongside.
 */
package asspc_pkg;

    // Source shown on the post-reset status pin.
    typedef enum logic {
        ASSPC_SRC_POWER,
        ASSPC_SRC_TMDS
    } asspc_src_t;

    // One open-drain or two-way pin as seen from the design.
    typedef struct packed {
        logic out;
        logic oe;
    } asspc_pin_drive_t;

endpackage : asspc_pkg

// ==== verilog/asspc_pin_ctrl.sv ====
/*
 * Address strap, status output and open-drain pin control.
 * Assumes i_reset_n is the internal power-on reset, already synchronous in release,
 * and that every other pin input may change at any time.
 */
// How it works
// [RULE1] While either reset holds the chip, the strap pin is only an input.
// [RULE2] Strap level is captured when power-on or external reset releases.
// [RULE3] Low strap selects address 0xB0, high strap selects 0xB2.
// [RULE4] After reset the strap pin drives selected port's 5 V presence.
// [RULE5] A control input switches the status pin to TMDS clock presence instead.
// [RULE6] Interrupt pin only pulls low, otherwise released for external pull-up.
// [RULE7] Configuration reaches the chip through clock input and open-drain data line.
// [RULE8] Each port's 5 V detect input is that port's presence indicator.
// [RULE9] Captured address holds until the next reset release.
`timescale 1ns/1ps
`include "asspc_defs.svh"

module asspc_pin_ctrl #(
    parameter int PORTS  = 4,
    parameter int SEL_W  = 2
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_ext_reset_n,
    input  wire logic                     i_strap_pin_in,
    input  wire logic [PORTS-1:0]         i_port_5v_detect,
    input  wire logic [SEL_W-1:0]         i_port_select,
    input  wire asspc_pkg::asspc_src_t    i_status_source,
    input  wire logic                     i_tmds_clock_present,
    input  wire logic                     i_irq_request,
    input  wire logic                     i_cfg_bus_clock,
    input  wire logic                     i_cfg_bus_data_in,
    input  wire logic                     i_cfg_bus_data_pull_low,
    output logic                          o_strap_pin_out,
    output logic                          o_strap_pin_oe,
    output logic [7:0]                    o_cfg_address,
    output logic                          o_in_reset,
    output logic                          o_irq_out,
    output logic                          o_irq_oe,
    output logic                          o_cfg_bus_clock,
    output logic                          o_cfg_bus_data,
    output logic                          o_cfg_bus_data_out,
    output logic                          o_cfg_bus_data_oe
);

    localparam int SYNC_W = PORTS + 4;
    localparam int IDX_EXT = 0;
    localparam int IDX_STRAP = 1;
    localparam int IDX_CLK = 2;
    localparam int IDX_DATA = 3;

    // Synchroniser stages and the filtered level of every pin input.
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] stable_reg;
    logic [SYNC_W-1:0] pins_raw;
    logic [2:0]        settle_reg;
    logic [2:0]        settle_next;
    logic              held_reg;
    logic              strap_level_reg;
    logic [7:0]        addr_next;
    logic              held_now;
    logic              release_now;
    logic              status_level;
    logic              presence;
    asspc_pkg::asspc_pin_drive_t strap_drive;
    asspc_pkg::asspc_pin_drive_t irq_drive;

    // A filtered level moves only once the second and third stages agree.
    function automatic logic agree_filter(input logic s2, input logic s3, input logic held);
        agree_filter = (s2 == s3) ? s3 : held;
    endfunction : agree_filter

    assign pins_raw = {i_port_5v_detect, i_cfg_bus_data_in, i_cfg_bus_clock,
                       i_strap_pin_in, i_ext_reset_n};

    // Three-stage synchroniser per pin; stage one feeds only stage two.
    generate
        for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    sync1_reg[g]  <= 1'b0;
                    sync2_reg[g]  <= 1'b0;
                    sync3_reg[g]  <= 1'b0;
                    stable_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g]  <= pins_raw[g];
                    sync2_reg[g]  <= sync1_reg[g];
                    sync3_reg[g]  <= sync2_reg[g];
                    stable_reg[g] <= agree_filter(sync2_reg[g], sync3_reg[g], stable_reg[g]);
                end
            end
        end
    endgenerate

    // Reset is held until the synchroniser has settled and the external reset reads high.
    assign settle_next = (settle_reg == `ASSPC_SETTLE_CYCLES) ? settle_reg
                                                                : settle_reg + 3'h1;
    assign held_now    = (settle_reg != `ASSPC_SETTLE_CYCLES) || !stable_reg[IDX_EXT]; // [RULE1]
    assign release_now = held_reg && !held_now;                                       // [RULE2]
    // The filtered strap is read directly, since it settles in the same cycle as the
    // filtered external reset and a registered copy would still hold the older level.
    assign addr_next   = stable_reg[IDX_STRAP] ? (`ASSPC_ADDR_LOW + `ASSPC_ADDR_STEP)
                                               : `ASSPC_ADDR_LOW;                     // [RULE3]

    // Presence of the selected port and the chosen status source.
    assign presence     = stable_reg[4 + 32'(i_port_select)];                        // [RULE8]
    assign status_level = (i_status_source == asspc_pkg::ASSPC_SRC_TMDS)
                        ? i_tmds_clock_present : presence;                            // [RULE5]

    // Strap pin is released while held; afterwards it drives the status level.
    assign strap_drive.oe  = !held_now;                                               // [RULE4]
    assign strap_drive.out = status_level;
    // Interrupt pin: drive low only, never drive high.
    assign irq_drive.oe    = i_irq_request;                                           // [RULE6]
    assign irq_drive.out   = 1'b0;

    // Settle counter and reset-held tracking.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            settle_reg <= `ASSPC_SETTLE_RESET;
            held_reg   <= 1'b1;
        end else begin
            settle_reg <= settle_next;
            held_reg   <= held_now;
        end
    end

    // Strap level follows the pin while held and keeps the level seen at the release edge.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_level_reg <= 1'b0;
        end else if (held_reg) begin
            strap_level_reg <= stable_reg[IDX_STRAP];                                 // [RULE1]
        end
    end

    // Address is loaded only at a release and otherwise kept.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_address <= `ASSPC_ADDR_LOW;
        end else if (release_now) begin
            o_cfg_address <= addr_next;                                               // [RULE9]
        end
    end

    // Registered pin drives and filtered configuration bus levels.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_strap_pin_out    <= 1'b0;
            o_strap_pin_oe     <= 1'b0;
            o_in_reset         <= 1'b1;
            o_irq_out          <= 1'b0;
            o_irq_oe           <= 1'b0;
            o_cfg_bus_clock    <= 1'b1;
            o_cfg_bus_data     <= 1'b1;
            o_cfg_bus_data_out <= 1'b0;
            o_cfg_bus_data_oe  <= 1'b0;
        end else begin
            o_strap_pin_out    <= strap_drive.out;
            o_strap_pin_oe     <= strap_drive.oe;
            o_in_reset         <= held_now;
            o_irq_out          <= irq_drive.out;
            o_irq_oe           <= irq_drive.oe;
            o_cfg_bus_clock    <= stable_reg[IDX_CLK];                                // [RULE7]
            o_cfg_bus_data     <= stable_reg[IDX_DATA];
            o_cfg_bus_data_out <= 1'b0;
            o_cfg_bus_data_oe  <= i_cfg_bus_data_pull_low;                            // [RULE7]
        end
    end

    // Pin is never driven while the chip is held in reset.
    property p_strap_input_in_reset;
        @(posedge i_clock) disable iff (!i_reset_n)
        held_now |=> !o_strap_pin_oe;
    endproperty
    a_strap_input_in_reset: assert property (p_strap_input_in_reset) // [RULE1]
        else $error("Strap pin driven during reset.");

    // Release loads the address from the captured strap level.
    property p_capture_at_release;
        @(posedge i_clock) disable iff (!i_reset_n)
        release_now |=> (o_cfg_address == $past(addr_next));
    endproperty
    a_capture_at_release: assert property (p_capture_at_release) // [RULE2]
        else $error("Address not loaded at reset release.");

    // Only the two legal addresses ever appear.
    property p_address_values;
        @(posedge i_clock) disable iff (!i_reset_n)
        (o_cfg_address == 8'hB0) || (o_cfg_address == 8'hB2);
    endproperty
    a_address_values: assert property (p_address_values) // [RULE3]
        else $error("Configuration address is neither 0xB0 nor 0xB2.");

    // Once running, the address matches the strap level kept at release.
    property p_strap_captured;
        @(posedge i_clock) disable iff (!i_reset_n)
        !held_reg |-> (o_cfg_address == (strap_level_reg ? 8'hB2 : 8'hB0));
    endproperty
    a_strap_captured: assert property (p_strap_captured) // [RULE3]
        else $error("Configuration address does not match the captured strap.");

    // With the power source selected, after release the status pin drives the selected presence one cycle later.
    property p_power_status;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!held_now && i_status_source == asspc_pkg::ASSPC_SRC_POWER)
            |=> (o_strap_pin_oe && o_strap_pin_out == $past(presence));
    endproperty
    a_power_status: assert property (p_power_status) // [RULE4]
        else $error("Status pin does not show port presence.");

    // With TMDS selected the pin follows the clock presence input.
    property p_tmds_status;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!held_now && i_status_source == asspc_pkg::ASSPC_SRC_TMDS)
            |=> (o_strap_pin_out == $past(i_tmds_clock_present));
    endproperty
    a_tmds_status: assert property (p_tmds_status) // [RULE5]
        else $error("Status pin does not show TMDS clock presence.");

    // Interrupt pin never drives high and enables on request.
    property p_irq_open_drain;
        @(posedge i_clock) disable iff (!i_reset_n)
        !o_irq_out && (o_irq_oe == $past(i_irq_request));
    endproperty
    a_irq_open_drain: assert property (p_irq_open_drain) // [RULE6]
        else $error("Interrupt pin not open-drain.");

    // Data line pulls low one cycle after the engine asks.
    property p_cfg_data_open_drain;
        @(posedge i_clock) disable iff (!i_reset_n)
        i_cfg_bus_data_pull_low |=> (o_cfg_bus_data_oe && !o_cfg_bus_data_out);
    endproperty
    a_cfg_data_open_drain: assert property (p_cfg_data_open_drain) // [RULE7]
        else $error("Configuration data line not pulled low.");

    // Presence pin level reaches the filtered indicator within four cycles.
    property p_presence_sync;
        @(posedge i_clock) disable iff (!i_reset_n)
        $rose(i_port_5v_detect[0]) ##1 i_port_5v_detect[0] [*4] |-> stable_reg[4];
    endproperty
    a_presence_sync: assert property (p_presence_sync) // [RULE8]
        else $error("Port presence not seen after synchronising.");

    // Address stays put while not at a release.
    property p_address_hold;
        @(posedge i_clock) disable iff (!i_reset_n)
        !release_now |=> $stable(o_cfg_address);
    endproperty
    a_address_hold: assert property (p_address_hold) // [RULE9]
        else $error("Address changed outside a reset release.");

    c_release_high: cover property (@(posedge i_clock) disable iff (!i_reset_n)
        release_now && stable_reg[IDX_STRAP]);
    c_ext_reset_cycle: cover property (@(posedge i_clock) disable iff (!i_reset_n)
        !held_reg ##1 held_reg ##[1:20] !held_reg);
    c_tmds_shown: cover property (@(posedge i_clock) disable iff (!i_reset_n)
        o_strap_pin_oe && i_status_source == asspc_pkg::ASSPC_SRC_TMDS);

endmodule : asspc_pin_ctrl

// ==== verification/asspc_board_model.sv ====
/*
 * Board and host model: strap resistor, interrupt pull-up, and the shared
 * configuration data line as a wired-and of host and device.
 * Assumes the design splits each open-drain or two-way pin into out and enable.
 */
`timescale 1ns/1ps

module asspc_board_model (
    input  wire logic i_strap_high,
    input  wire logic i_strap_out,
    input  wire logic i_strap_oe,
    input  wire logic i_irq_oe,
    input  wire logic i_data_oe,
    input  wire logic i_host_pull_low,
    output logic      o_strap_level,
    output logic      o_irq_level,
    output logic      o_data_level
);
    // The strap resistor sets the level whenever the device releases the pin.
    assign o_strap_level = i_strap_oe ? i_strap_out : i_strap_high;
    // The pull-up holds the interrupt line high unless the device pulls it low.
    assign o_irq_level = ~i_irq_oe;
    // Either party may pull the data line low, and the pull-up restores it.
    assign o_data_level = ~(i_data_oe | i_host_pull_low);
endmodule : asspc_board_model

// ==== verification/asspc_pin_ctrl_bench.sv ====
/*
 * Self-checking bench for the strap, status and open-drain pin control.
 * Assumes the design package and constants header are compiled first.
 */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module asspc_pin_ctrl_bench;
    typedef struct packed {
        logic [1:0] sel;
        logic [3:0] det;
        logic       src;
        logic       tmds;
        logic       exp;
    } asspc_row_t;
    logic       i_clock, i_reset_n, i_ext_reset_n, strap_high, host_low, eng_low, scl;
    logic [3:0] det;
    logic [1:0] sel;
    logic       src, tmds, irq_req, strap_level, irq_level, data_level;
    logic       strap_out, strap_oe, in_reset, irq_oe, scl_f, sda_f, sda_oe;
    logic       irq_out, sda_out;
    logic [7:0] addr;
    int         fail_count, cmp_count;
    asspc_row_t rows [7] = '{'{2'h0, 4'h1, 1'h0, 1'h0, 1'h1}, '{2'h1, 4'h1, 1'h0, 1'h0, 1'h0},
        '{2'h2, 4'h4, 1'h0, 1'h0, 1'h1}, '{2'h3, 4'h7, 1'h0, 1'h0, 1'h0},
        '{2'h3, 4'h8, 1'h0, 1'h0, 1'h1}, '{2'h0, 4'h0, 1'h1, 1'h1, 1'h1},
        '{2'h0, 4'hF, 1'h1, 1'h0, 1'h0}};

    asspc_pin_ctrl asspc_pin_ctrl_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_ext_reset_n(i_ext_reset_n), .i_strap_pin_in(strap_level), .i_port_5v_detect(det),
        .i_port_select(sel), .i_status_source(asspc_pkg::asspc_src_t'(src)),
        .i_tmds_clock_present(tmds), .i_irq_request(irq_req), .i_cfg_bus_clock(scl),
        .i_cfg_bus_data_in(data_level), .i_cfg_bus_data_pull_low(eng_low),
        .o_strap_pin_out(strap_out), .o_strap_pin_oe(strap_oe), .o_cfg_address(addr),
        .o_in_reset(in_reset), .o_irq_out(irq_out), .o_irq_oe(irq_oe),
        .o_cfg_bus_clock(scl_f), .o_cfg_bus_data(sda_f), .o_cfg_bus_data_out(sda_out),
        .o_cfg_bus_data_oe(sda_oe));

    asspc_board_model asspc_board_model_i (.i_strap_high(strap_high), .i_strap_out(strap_out),
        .i_strap_oe(strap_oe), .i_irq_oe(irq_oe), .i_data_oe(sda_oe), .i_host_pull_low(host_low),
        .o_strap_level(strap_level), .o_irq_level(irq_level), .o_data_level(data_level));

    // The clock toggles every half period of 25 ns.
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // Waits n rising edges, then settles to the falling edge for sampling.
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask : step

    // Waits a bounded time for the chip to leave reset.
    task automatic wait_ready();
        int n;
        n = 0;
        while (in_reset !== 1'b0 && n < 30) begin
            @(negedge i_clock);
            n++;
        end
        if (n == 30) `CHK("reset release", 1'b0, in_reset)
    endtask : wait_ready

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // A hang is cut short well after the expected run length.
    initial begin
        #(3000 * 50);
        fail_count++;
        final_report();
    end

    // Main sequence: power-on strap, status table, open-drain pins, resets.
    initial begin
        {i_reset_n, host_low, eng_low, scl, det, sel, src, tmds, irq_req} = '0;
        {i_ext_reset_n, strap_high} = 2'h3;
        fail_count = 0;
        cmp_count = 0;
        step(15);
        `CHK("strap oe in reset", 1'b0, strap_oe)
        `CHK("in reset", 1'b1, in_reset)
        `CHK("irq oe in reset", 1'b0, irq_oe)
        @(posedge i_clock) i_reset_n <= 1'b1;
        wait_ready();
        `CHK("address high strap", 8'hB2, addr)
        `CHK("strap oe after reset", 1'b1, strap_oe)
        $display("test power-on strap done");
        foreach (rows[k]) begin
            @(posedge i_clock) {sel, det, src, tmds} <= rows[k][8:1];
            step(8);
            `CHK("status pin", rows[k].exp, strap_level)
            `CHK("address held", 8'hB2, addr)
        end
        $display("test status table done");
        @(posedge i_clock) irq_req <= 1'b1;
        step(2);
        `CHK("irq pulled low", 1'b0, irq_level)
        `CHK("irq never driven high", 1'b0, irq_out)
        @(posedge i_clock) irq_req <= 1'b0;
        step(2);
        `CHK("irq released", 1'b1, irq_level)
        @(posedge i_clock) eng_low <= 1'b1;
        step(8);
        `CHK("data driven low", 1'b0, data_level)
        `CHK("data drive level", 1'b0, sda_out)
        `CHK("data seen low", 1'b0, sda_f)
        @(posedge i_clock) {eng_low, host_low, scl} <= 3'h3;
        step(8);
        `CHK("data not driven", 1'b0, sda_oe)
        `CHK("host data seen", 1'b0, sda_f)
        `CHK("bus clock seen", 1'b1, scl_f)
        @(posedge i_clock) {host_low, scl} <= 2'h0;
        step(8);
        `CHK("data released", 1'b1, sda_f)
        `CHK("bus clock low", 1'b0, scl_f)
        $display("test open-drain pins done");
        @(posedge i_clock) {strap_high, i_ext_reset_n} <= 2'h0;
        step(8);
        `CHK("in ext reset", 1'b1, in_reset)
        `CHK("strap released", 1'b0, strap_oe)
        `CHK("address kept", 8'hB2, addr)
        @(posedge i_clock) i_ext_reset_n <= 1'b1;
        wait_ready();
        `CHK("address low strap", 8'hB0, addr)
        $display("test external reset done");
        @(posedge i_clock) {strap_high, i_reset_n} <= 2'h2;
        step(4);
        @(posedge i_clock) i_reset_n <= 1'b1;
        wait_ready();
        `CHK("address second power-on", 8'hB2, addr)
        $display("test second power-on done");
        final_report();
    end
endmodule : asspc_pin_ctrl_bench
